// ### design/prn_cas_port.sv
// printer port, cassette select latch and expansion RAM decode
//
// Notes on behaviour
// RQ1: one-bit latch picks recorder one or two
// RQ2: printer port at one address, read and write
// RQ3: read returns busy, paper, unselected, no-fault
// RQ4: written byte goes out as printer data
// RQ5: printer busy high means do not send
// RQ6: printer takes seven or eight bit codes
// RQ7: undriven select and fault read as high
// RQ8: printer lacking paper signal grounds that input
// RQ9: RAM in 16K blocks, 32K max, host full
// RQ10: status reads show live input levels
`timescale 1ns/10ps
module prn_cas_port
  import prn_cas_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  bus_req_s        bus_req,
  output logic            bus_wait,
  output logic            rd_valid,
  output logic            rd_hit,
  output logic [7:0]      rd_data,
  input  wire logic       host_ram_full,
  input  wire logic [1:0] ram_blocks,
  input  prn_stat_s       prn_stat,
  output logic [7:0]      prn_data,
  output logic            prn_strobe_n,
  output logic            cas1_active,
  output logic            cas2_active
);

  // ---------------------------------------------------------------
  // address decode helpers
  // ---------------------------------------------------------------

  // true when the host is full and the address falls in a populated expansion block
  function automatic logic exp_hit(input logic [15:0] a,
                                   input logic [1:0]  blocks,
                                   input logic        full);
    logic blk;
    blk = a[EXP_BLK_BIT];
    exp_hit = full && (a >= EXP_RAM_BASE) &&
              ({1'b0, blk} < blocks); // RQ9
  endfunction

  logic [1:0] blocks_q;   // populated block count, caught at release
  logic       strap_done; // strap already taken
  logic       ram_sel;    // current cycle addresses RAM
  logic       prn_sel;    // current cycle addresses printer
  logic       cas_sel;    // current cycle addresses cassette latch

  assign ram_sel = exp_hit(bus_req.addr, blocks_q, host_ram_full);
  assign prn_sel = (bus_req.addr == PRN_ADDR);   // RQ2
  assign cas_sel = (bus_req.addr == CAS_SEL_ADDR);

  // ---------------------------------------------------------------
  // block-count strap
  // ---------------------------------------------------------------

  // strap sampled on the first edge after release, never in reset;
  // a count above two is clipped since only 32K fits
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      blocks_q   <= 2'h0;
      strap_done <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      if (ram_blocks > EXP_BLK_MAX)
        blocks_q <= EXP_BLK_MAX; // RQ9
      else
        blocks_q <= ram_blocks;
    end
  end

  // ---------------------------------------------------------------
  // cassette select latch
  // ---------------------------------------------------------------
  logic cas_q; // 0 = recorder one

  // only bit zero is kept; the rest of the byte is ignored
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cas_q <= CAS_SEL_RST;
    else if (bus_req.wr && cas_sel)
      cas_q <= bus_req.data[CAS_SEL_BIT]; // RQ1
  end

  // exactly one recorder routed at any time
  assign cas1_active = !cas_q; // RQ1
  assign cas2_active = cas_q;  // RQ1

  // ---------------------------------------------------------------
  // printer status bits
  // ---------------------------------------------------------------
  logic [1:0] opt_lvl; // select, no-fault after pull-up
  logic [1:0] opt_in;  // raw levels
  logic [1:0] opt_drv; // printer actually drives the line
  logic [7:0] status;  // byte a read returns

  assign opt_in  = {prn_stat.select, prn_stat.fault_n};
  assign opt_drv = {prn_stat.select_drv, prn_stat.fault_drv};

  // an undriven optional line floats to the pulled-up level
  for (genvar i = 0; i < 2; i++)
  begin : g_pull
    assign opt_lvl[i] = opt_drv[i] ? opt_in[i] : 1'b1; // RQ7
  end

  // live levels, nothing latched; paper out relies on the printer
  // side grounding the line when it has no such signal
  always_comb
  begin
    status               = 8'h00;
    status[ST_BUSY_BIT]  = prn_stat.busy;      // RQ3 RQ10
    status[ST_PAPER_BIT] = prn_stat.paper_out; // RQ3 RQ8
    status[ST_NSEL_BIT]  = !opt_lvl[1];        // RQ3 RQ7
    status[ST_NOFLT_BIT] = opt_lvl[0];         // RQ3 RQ7
  end

  // ---------------------------------------------------------------
  // printer write path into the FIFO
  // ---------------------------------------------------------------
  logic       fifo_in_valid; // host write aimed at printer
  logic       fifo_in_ready; // room left
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [7:0] fifo_out_data;

  assign fifo_in_valid = bus_req.wr && prn_sel;
  // host is stalled rather than losing a byte when eight queue up
  assign bus_wait      = fifo_in_valid && !fifo_in_ready;

  byte_fifo #(
    .WIDTH (PRN_FIFO_W),
    .DEPTH (PRN_FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (bus_req.data),   // RQ4
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------
  // printer output sequencer
  // ---------------------------------------------------------------
  prn_state_e       st_q;  // sequencer state
  logic [TMR_W-1:0] tmr_q; // cycles left in current phase
  logic             tmr_end;

  assign tmr_end = (tmr_q == '0);
  // a byte leaves the FIFO only when the printer says it can take it
  assign fifo_out_ready = (st_q == PRN_IDLE) && fifo_out_valid &&
                          !prn_stat.busy; // RQ5

  // setup, strobe, hold; busy is only checked before a new byte
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= PRN_IDLE;
    else
    begin
      case (st_q)
        PRN_IDLE:
          if (fifo_out_ready)
            st_q <= PRN_SETUP; // RQ5
        PRN_SETUP:
          if (tmr_end)
            st_q <= PRN_STROBE;
        PRN_STROBE:
          if (tmr_end)
            st_q <= PRN_HOLD;
        PRN_HOLD:
          if (tmr_end)
            st_q <= PRN_IDLE;
        default:
          st_q <= PRN_IDLE;
      endcase
    end
  end

  // phase timer, loaded with count minus one on each entry
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tmr_q <= '0;
    else
    begin
      case (st_q)
        PRN_IDLE:
          tmr_q <= TMR_W'(SETUP_CYC - 1);
        PRN_SETUP:
          if (tmr_end)
            tmr_q <= TMR_W'(STROBE_CYC - 1);
          else
            tmr_q <= tmr_q - 1'b1;
        PRN_STROBE:
          if (tmr_end)
            tmr_q <= TMR_W'(HOLD_CYC - 1);
          else
            tmr_q <= tmr_q - 1'b1;
        PRN_HOLD:
          if (!tmr_end)
            tmr_q <= tmr_q - 1'b1;
        default:
          tmr_q <= '0;
      endcase
    end
  end

  // data held stable from setup through hold; all eight bits go out,
  // a seven-bit printer simply ignores bit seven
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prn_data <= 8'h00;
    else if (fifo_out_ready)
      prn_data <= fifo_out_data; // RQ4 RQ6
  end

  // active-low strobe from a flop, high outside the strobe phase
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prn_strobe_n <= 1'b1;
    else
      prn_strobe_n <= !((st_q == PRN_SETUP && tmr_end) ||
                        (st_q == PRN_STROBE && !tmr_end));
  end

  // ---------------------------------------------------------------
  // expansion RAM
  // ---------------------------------------------------------------
  logic       ram_en;
  logic [7:0] ram_rdata;

  assign ram_en = ram_sel && (bus_req.rd || bus_req.wr); // RQ9

  exp_ram u_ram (
    .clk   (clk),
    .en    (ram_en),
    .we    (bus_req.wr),
    .addr  (bus_req.addr[EXP_ADDR_W-1:0]),
    .wdata (bus_req.data),
    .rdata (ram_rdata)
  );

  // ---------------------------------------------------------------
  // read return, two stages
  // ---------------------------------------------------------------
  logic       rd1_q;   // read accepted last cycle
  logic       ram1_q;  // it targeted RAM
  logic       hit1_q;  // it targeted RAM or the printer port
  logic [7:0] reg1_q;  // captured status byte

  // status is sampled in the request cycle itself, so the byte
  // shows the printer lines as they were when the host asked
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd1_q  <= 1'b0;
      ram1_q <= 1'b0;
      hit1_q <= 1'b0;
      reg1_q <= 8'h00;
    end
    else
    begin
      rd1_q  <= bus_req.rd;
      ram1_q <= bus_req.rd && ram_sel;
      hit1_q <= bus_req.rd && (ram_sel || prn_sel);
      reg1_q <= prn_sel ? status : UNMAPPED_DATA; // RQ3 RQ10
    end
  end

  // second stage picks RAM or register and holds until next read;
  // the write-only cassette latch reads as unmapped
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_valid <= 1'b0;
      rd_hit   <= 1'b0;
      rd_data  <= UNMAPPED_DATA;
    end
    else
    begin
      rd_valid <= rd1_q;
      if (rd1_q)
      begin
        rd_hit  <= hit1_q;
        rd_data <= ram1_q ? ram_rdata : reg1_q;
      end
    end
  end

endmodule

// ### design/prn_cas_pkg.sv
// shared constants and carriers for the printer/cassette block
package prn_cas_pkg;

  // ---------------------------------------------------------------
  // host memory map
  // ---------------------------------------------------------------
  localparam logic [15:0] CAS_SEL_ADDR  = 16'h37E4; // cassette latch
  localparam logic [15:0] PRN_ADDR      = 16'h37E8; // printer port
  localparam logic [15:0] EXP_RAM_BASE  = 16'h8000; // first 16K block
  localparam int          EXP_ADDR_W    = 15;       // 32K window
  localparam int          EXP_BLK_BIT   = 14;       // 16K block select
  localparam logic [1:0]  EXP_BLK_MAX   = 2'h2;     // two blocks max
  localparam logic [7:0]  UNMAPPED_DATA = 8'h00;    // idle read value

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CAS_SEL_BIT  = 0; // 0 = recorder one, 1 = two
  localparam int ST_BUSY_BIT  = 7;
  localparam int ST_PAPER_BIT = 6;
  localparam int ST_NSEL_BIT  = 5;
  localparam int ST_NOFLT_BIT = 4;
  localparam logic CAS_SEL_RST = 1'b0; // recorder one after reset

  // ---------------------------------------------------------------
  // printer output buffering and strobe timing
  // ---------------------------------------------------------------
  localparam int PRN_FIFO_W = 8;
  localparam int PRN_FIFO_D = 8;
  localparam int CLK_MHZ    = 25;
  localparam int SETUP_NS   = 500;  // data before strobe
  localparam int STROBE_NS  = 1000; // strobe width
  localparam int HOLD_NS    = 500;  // data after strobe
  localparam int SETUP_CYC  = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC   = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W      = 6;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        rd;   // one-cycle read strobe
    logic        wr;   // write strobe, held while wait is high
    logic [15:0] addr;
    logic [7:0]  data;
  } bus_req_s;

  typedef struct packed {
    logic busy;       // high = cannot accept
    logic paper_out;  // high = out of paper
    logic select;     // high = selected
    logic select_drv; // printer drives select
    logic fault_n;    // high = no fault
    logic fault_drv;  // printer drives fault
  } prn_stat_s;

  typedef enum logic [1:0] {
    PRN_IDLE,
    PRN_SETUP,
    PRN_STROBE,
    PRN_HOLD
  } prn_state_e;

endpackage

// ### design/byte_fifo.sv
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo
  import prn_cas_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // word store
  logic [AW:0]      wp_q;          // extra bit tells full from empty
  logic [AW:0]      rp_q;
  logic             push;
  logic             pop;

  assign in_ready  = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
  assign out_valid = (wp_q != rp_q);
  assign out_data  = mem_q[rp_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // write side
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wp_q <= '0;
    else if (push)
      wp_q <= wp_q + 1'b1;
  end

  // data store, no reset needed
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q[AW-1:0]] <= in_data;
  end

  // read side
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rp_q <= '0;
    else if (pop)
      rp_q <= rp_q + 1'b1;
  end

endmodule

// ### design/exp_ram.sv
// expansion RAM, up to two 16K blocks, registered read
`timescale 1ns/10ps
module exp_ram
  import prn_cas_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  en,
  input  wire logic                  we,
  input  wire logic [EXP_ADDR_W-1:0] addr,
  input  wire logic [7:0]            wdata,
  output logic      [7:0]            rdata
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] mem_q [2**EXP_ADDR_W]; // full 32K, gated by caller

  // one port: write or registered read
  always_ff @(posedge clk)
  begin
    if (en && we)
      mem_q[addr] <= wdata;
    if (en)
      rdata <= mem_q[addr];
  end

endmodule

// ### tb/prn_cas_checker.sv
// assertion checker for the printer and cassette port
`timescale 1ns/10ps
module prn_cas_checker
  import prn_cas_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input bus_req_s        bus_req,
  input wire logic       bus_wait,
  input wire logic       rd_valid,
  input wire logic       rd_hit,
  input wire logic [7:0] rd_data,
  input wire logic       host_ram_full,
  input prn_stat_s       prn_stat,
  input wire logic [7:0] prn_data,
  input wire logic       prn_strobe_n,
  input wire logic       cas1_active,
  input wire logic       cas2_active
);
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  logic [7:0] st_exp; // status byte the inputs call for
  logic [5:0] low_q;  // length of the current strobe pulse
  assign st_exp = {prn_stat.busy, prn_stat.paper_out,
                   prn_stat.select_drv & ~prn_stat.select,
                   ~prn_stat.fault_drv | prn_stat.fault_n, 4'h0};
  // run counter, avoids a long repetition in the property
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      low_q <= 6'h00;
    else if (!prn_strobe_n)
      low_q <= low_q + 6'h01;
    else
      low_q <= 6'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd(logic [15:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  sequence s_ans;
    ##2 rd_valid;
  endsequence
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  a_cas_one_hot: assert property (cas1_active != cas2_active)
    else $error("cassette selects not exclusive");
  a_cas_latch_write: assert property (bus_req.wr &&
    bus_req.addr == CAS_SEL_ADDR |=> cas2_active == $past(bus_req.data[0]))
    else $error("cassette latch did not follow write");
  a_cas_read_miss: assert property (s_rd(CAS_SEL_ADDR) |->
    s_ans ##0 !rd_hit && rd_data == 8'h00)
    else $error("cassette latch read not empty");
  a_status_read: assert property (s_rd(PRN_ADDR) |->
    s_ans ##0 rd_hit && rd_data == $past(st_exp, 2))
    else $error("printer status read wrong");
  a_valid_cause: assert property (rd_valid |-> $past(bus_req.rd, 2))
    else $error("read answer without request");
  a_ram_gated: assert property (bus_req.rd && !host_ram_full &&
    bus_req.addr[15] |-> s_ans ##0 !rd_hit)
    else $error("expansion memory answered without host memory");
  a_wait_cause: assert property (bus_wait |->
    bus_req.wr && bus_req.addr == PRN_ADDR)
    else $error("wait raised outside printer write");
  a_strobe_width: assert property ($rose(prn_strobe_n) |->
    low_q == STROBE_CYC)
    else $error("strobe width wrong");
  a_data_setup: assert property ($fell(prn_strobe_n) |->
    $past(prn_data, 12) == prn_data && !$past(prn_stat.busy, 14))
    else $error("strobe without setup or while busy");
  a_data_hold: assert property (!prn_strobe_n |-> $stable(prn_data))
    else $error("printer data moved during strobe");
endmodule

bind prn_cas_port prn_cas_checker i_chk (.clk, .arst_n, .bus_req, .bus_wait,
  .rd_valid, .rd_hit, .rd_data, .host_ram_full, .prn_stat, .prn_data,
  .prn_strobe_n, .cas1_active, .cas2_active);

// ### tb/printer_model.sv
// behavioural parallel printer on the far side of the port
`timescale 1ns/10ps
module printer_model
  import prn_cas_pkg::*;
(
  input wire logic       clk,
  input wire logic [7:0] prn_data,
  input wire logic       prn_strobe_n,
  input wire logic       force_busy,
  input wire logic [4:0] lines,
  input wire logic [7:0] busy_len,
  output prn_stat_s      prn_stat
);
  logic [7:0] busy_q; // busy cycles left after a byte
  logic       prev_q; // strobe level one edge ago
  logic [7:0] got[$]; // bytes printed, oldest first
  // whole 8-bit code taken on strobe fall, then busy
  always @(posedge clk)
  begin
    prev_q <= prn_strobe_n;
    if (prev_q === 1'b1 && prn_strobe_n === 1'b0)
    begin
      got.push_back(prn_data);
      busy_q <= busy_len;
    end
    else if (busy_q != 8'h00)
      busy_q <= busy_q - 8'h01;
  end
  // undriven optional lines show a wrong level, device must ignore
  assign prn_stat = '{busy: force_busy | (busy_q != 8'h00),
                      paper_out: lines[4],
                      select: lines[2] ? lines[3] : ~lines[3],
                      select_drv: lines[2],
                      fault_n: lines[0] ? lines[1] : ~lines[1],
                      fault_drv: lines[0]};
  initial busy_q = 8'h00;
endmodule

// ### tb/tb.sv
// self-checking bench for the printer and cassette port
`timescale 1ns/10ps
module tb
  import prn_cas_pkg::*;
;
  logic       clk, arst_n, bus_wait, rd_valid, rd_hit, w;
  logic       host_ram_full, prn_strobe_n, cas1_active, cas2_active;
  logic       force_busy;
  logic [1:0] ram_blocks;
  logic [4:0] lines;
  logic [7:0] rd_data, prn_data, busy_len;
  logic [7:0] exp_q[$];
  bus_req_s   bus_req;
  prn_stat_s  prn_stat;
  int         err_count, n_checks;
  // status rows: busy, paper, sel, sel_drv, flt_n, flt_drv, byte
  logic [13:0] rows [6] = '{14'h0F10, 14'h2F90, 14'h1F50,
                            14'h0520, 14'h0010, 14'h35E0};
  prn_cas_port i_dut (.clk, .arst_n, .bus_req, .bus_wait, .rd_valid,
    .rd_hit, .rd_data, .host_ram_full, .ram_blocks, .prn_stat,
    .prn_data, .prn_strobe_n, .cas1_active, .cas2_active);
  printer_model i_prn (.clk, .prn_data, .prn_strobe_n, .force_busy,
    .lines, .busy_len, .prn_stat);
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic report_and_stop;
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  // write held until the port stops asking to wait
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d,
                        output logic waited);
    int n;
    waited = 1'b0;
    @(posedge clk);
    bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, data: d};
    for (n = 0; n < 5000; n++)
    begin
      @(posedge clk);
      if (bus_wait === 1'b0)
        break;
      waited = 1'b1;
    end
    if (n == 5000)
    begin
      err_count++;
      report_and_stop;
    end
    bus_req.wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [15:0] a, input logic h,
                        input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, data: 8'h00};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(posedge clk);
    #1;
    chk_bit(rd_valid, 1'b1);
    chk_bit(rd_hit, h);
    chk_byte(rd_data, d);
  endtask
  task automatic prn_put(input logic [7:0] d);
    exp_q.push_back(d);
    bus_wr(PRN_ADDR, d, w);
  endtask
  task automatic wait_got(input int n);
    int k;
    for (k = 0; k < 3000 && i_prn.got.size() < n; k++)
      @(posedge clk);
    if (k == 3000)
    begin
      err_count++;
      report_and_stop;
    end
  endtask
  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    arst_n = 1'b0;
    bus_req = '0;
    host_ram_full = 1'b1;
    ram_blocks = 2'h2;
    force_busy = 1'b0;
    lines = 5'h0F;
    busy_len = 8'h01;
    err_count = 0;
    n_checks = 0;
    do_reset;
    chk_bit(cas1_active, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      {force_busy, lines} <= rows[i][13:8];
      bus_rd(PRN_ADDR, 1'b1, rows[i][7:0]);
    end
    @(posedge clk);
    force_busy <= 1'b0;
    lines <= 5'h0F;
    bus_wr(CAS_SEL_ADDR, 8'h01, w);
    #1;
    chk_bit(cas2_active, 1'b1);
    bus_rd(CAS_SEL_ADDR, 1'b0, 8'h00);
    bus_wr(CAS_SEL_ADDR, 8'h00, w);
    #1;
    chk_bit(cas1_active, 1'b1);
    bus_wr(EXP_RAM_BASE, 8'h5A, w);
    bus_wr(16'hC000, 8'hA5, w);
    bus_rd(EXP_RAM_BASE, 1'b1, 8'h5A);
    bus_rd(16'hC000, 1'b1, 8'hA5);
    bus_rd(16'h3000, 1'b0, UNMAPPED_DATA);
    @(posedge clk);
    host_ram_full <= 1'b0;
    bus_rd(EXP_RAM_BASE, 1'b0, UNMAPPED_DATA);
    // latch left on recorder two must fall back on mid-run reset
    bus_wr(CAS_SEL_ADDR, 8'h01, w);
    host_ram_full <= 1'b1;
    ram_blocks <= 2'h1;
    do_reset;
    chk_bit(cas1_active, 1'b1);
    chk_bit(rd_valid, 1'b0);
    bus_rd(16'hC000, 1'b0, UNMAPPED_DATA);
    // slow printer: port must hold off while busy
    busy_len <= 8'h64;
    prn_put(8'h41);
    prn_put(8'hC3);
    wait_got(2);
    // printer held busy so the queue fills to refusal
    force_busy <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      prn_put(8'h30 + 8'(i));
      chk_bit(w, 1'b0);
    end
    fork
      prn_put(8'h7E);
      begin
        repeat (20) @(posedge clk);
        force_busy <= 1'b0;
      end
    join
    chk_bit(w, 1'b1);
    wait_got(11);
    for (int i = 0; i < 11; i++)
      chk_byte(i_prn.got[i], exp_q[i]);
    report_and_stop;
  end
endmodule
